// File: core/chglim_pkg.sv
// package: register map, defaults and carrier types of the charger limit setting bank
package chglim_pkg;

  // register offsets on the serial link
  localparam logic [7:0] CHGLIM_OFS_VIN_FLOOR = 8'h06;
  localparam logic [7:0] CHGLIM_OFS_IIN_CAP   = 8'h08;
  localparam logic [7:0] CHGLIM_OFS_SRC_VOUT  = 8'h09;
  localparam logic [7:0] CHGLIM_OFS_COMP_ISRC = 8'h0a;

  // writable bits of each register; the rest read as zero
  localparam logic [15:0] CHGLIM_MSK_VIN_FLOOR = 16'h00ff;
  localparam logic [15:0] CHGLIM_MSK_IIN_CAP   = 16'h007f;
  localparam logic [15:0] CHGLIM_MSK_SRC_VOUT  = 16'hffff;
  localparam logic [15:0] CHGLIM_MSK_COMP_ISRC = 16'h3f7f;

  // field positions
  localparam int CHGLIM_POS_VSRC_FB   = 10;
  localparam int CHGLIM_POS_VSRC_OS   = 11;
  localparam int CHGLIM_POS_VSRC_HI   = 12;
  localparam int CHGLIM_POS_CLAMP     = 8;
  localparam int CHGLIM_POS_CELL_R    = 11;

  // values after reset (codes)
  localparam logic [7:0] CHGLIM_RST_VIN_MIN = 8'h39;   // 57 x 80 mV = 4.56 V
  localparam logic [6:0] CHGLIM_RST_IIN_LIM = 7'h0a;   // 10 x 50 mA = 500 mA
  localparam logic [9:0] CHGLIM_RST_VSRC    = 10'h0f9; // 249 x 20 mV = 4.98 V
  localparam logic [6:0] CHGLIM_RST_ISRC    = 7'h28;   // 40 x 50 mA = 2 A
  localparam logic [2:0] CHGLIM_RST_CELL_R  = 3'h0;
  localparam logic [2:0] CHGLIM_RST_CLAMP   = 3'h0;

  // source voltage offset expressed in steps of the source voltage code
  localparam int CHGLIM_VSRC_LSB_MV = 20;
  localparam int CHGLIM_VSRC_OFS_MV = 640;
  localparam logic [10:0] CHGLIM_VSRC_OFS_STEPS = 11'(CHGLIM_VSRC_OFS_MV / CHGLIM_VSRC_LSB_MV);

  // serial byte engine counts
  localparam logic [3:0] CHGLIM_BIT_LAST = 4'h7;
  localparam logic [3:0] CHGLIM_BIT_ACK  = 4'h8;
  localparam logic [3:0] CHGLIM_BIT_DONE = 4'h9;

  typedef struct packed {
    logic [7:0] vin_min;
    logic [6:0] iin_lim;
    logic [3:0] vsrc_spare;
    logic       source_voltage_offset_sel;
    logic       vsrc_from_fb;
    logic [9:0] vsrc;
    logic [2:0] cell_resistance_code;
    logic [2:0] comp_clamp_code;
    logic [6:0] isrc_lim;
  } chglim_cfg_t;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       rx_valid;
    logic [7:0] rx_byte;
    logic       ack_seen;
    logic       host_ack;
  } chglim_evt_t;

  typedef enum logic [2:0] {
    CHGLIM_IDLE,
    CHGLIM_ADDR,
    CHGLIM_CMD,
    CHGLIM_DLO,
    CHGLIM_DHI,
    CHGLIM_READ,
    CHGLIM_SKIP
  } chglim_ph_t;

endpackage

// File: core/chglim_byte_engine.sv
// serial link byte engine: start/stop detect, byte shifting, acknowledge drive
`timescale 1ns/1ps
module chglim_byte_engine (
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  input  wire logic                ack_en,
  input  wire logic                tx_mode,
  input  wire logic [7:0]          tx_byte,
  output chglim_pkg::chglim_evt_t  evt,
  output logic                     sda_oe_n
);
  import chglim_pkg::*;

  typedef struct packed {
    logic        scl_q;
    logic        sda_q;
    logic        busy;
    logic        txing;
    logic [3:0]  bitcnt;
    logic [7:0]  sh;
    logic        oe_n;
    chglim_evt_t evt;
  } chglim_eng_t;

  chglim_eng_t eng_ff;
  chglim_eng_t nxt_eng;

  logic [7:0] shifted;
  assign shifted = {eng_ff.sh[6:0], sda_in};

  always_comb begin
    nxt_eng       = eng_ff;
    nxt_eng.scl_q = scl_in;
    nxt_eng.sda_q = sda_in;
    nxt_eng.evt   = '0;
    if (eng_ff.scl_q && scl_in && eng_ff.sda_q && !sda_in) begin
      nxt_eng.evt.start = 1'b1;
      nxt_eng.busy      = 1'b1;
      nxt_eng.txing     = 1'b0;
      nxt_eng.bitcnt    = '0;
      nxt_eng.oe_n      = 1'b1;
    end else if (eng_ff.scl_q && scl_in && !eng_ff.sda_q && sda_in) begin
      nxt_eng.evt.stop = 1'b1;
      nxt_eng.busy     = 1'b0;
      nxt_eng.txing    = 1'b0;
      nxt_eng.oe_n     = 1'b1;
    end else if (eng_ff.busy && scl_in && !eng_ff.scl_q) begin
      if (eng_ff.bitcnt == CHGLIM_BIT_ACK) begin
        if (eng_ff.txing) begin
          nxt_eng.evt.ack_seen = 1'b1;
          nxt_eng.evt.host_ack = !sda_in;
        end
      end else begin
        nxt_eng.sh = shifted;
        if (eng_ff.bitcnt == CHGLIM_BIT_LAST && !eng_ff.txing) begin
          nxt_eng.evt.rx_valid = 1'b1;
          nxt_eng.evt.rx_byte  = shifted;
        end
      end
      nxt_eng.bitcnt = eng_ff.bitcnt + 4'h1;
    end else if (eng_ff.busy && !scl_in && eng_ff.scl_q) begin
      if (eng_ff.bitcnt == CHGLIM_BIT_ACK) begin
        // acknowledge slot: pull low only when the bank accepted the byte
        nxt_eng.oe_n = eng_ff.txing | !ack_en;
      end else if (eng_ff.bitcnt == CHGLIM_BIT_DONE) begin
        nxt_eng.bitcnt = '0;
        nxt_eng.txing  = tx_mode;
        nxt_eng.sh     = tx_byte;
        nxt_eng.oe_n   = tx_mode ? tx_byte[7] : 1'b1;
      end else if (eng_ff.txing && eng_ff.bitcnt != 4'h0) begin
        nxt_eng.oe_n = eng_ff.sh[7];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      eng_ff       <= '0;
      eng_ff.scl_q <= 1'b1;
      eng_ff.sda_q <= 1'b1;
      eng_ff.oe_n  <= 1'b1;
    end else begin
      eng_ff <= nxt_eng;
    end
  end

  assign evt      = eng_ff.evt;
  assign sda_oe_n = eng_ff.oe_n;

endmodule

// File: core/chglim_setting_bank.sv
// charger limit setting register bank reached over the serial link
//
// What this block does
// - input voltage floor is 8-bit code, 80 mV steps, default 4.56 V, watchdog restores.
// - power-up defaults of voltage floor and current cap may come from OTP.
// - input current cap is 7-bit code, 50 mA steps, default 500 mA, watchdog restores.
// - offset select bit adds 0.64 V to the source voltage target.
// - method bit 10 is only stored and read back; the setpoint always uses the register code.
// - cell resistance code bits 13:11, 50 mOhm per cell step, default zero, watchdog clears.
// - compensation clamp code bits 10:8, 60 mV per cell step, default zero.
// - source current limit bits 6:0, 50 mA steps, default 2 A, watchdog restores.
// - device answers at 7-bit address whose upper four bits come from OTP.
`timescale 1ns/1ps
module chglim_setting_bank #(
  parameter logic [2:0] DEV_ADDR_LO = 3'h1
) (
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe_n,
  input  wire logic                otp_valid,
  input  wire logic [7:0]          otp_vin_min,
  input  wire logic [6:0]          otp_iin_lim,
  input  wire logic [3:0]          otp_addr_hi,
  input  wire logic                supervision_timer_expired,
  output chglim_pkg::chglim_cfg_t  cfg,
  output logic [10:0]              vsrc_target_code
);
  import chglim_pkg::*;

  typedef struct packed {
    chglim_ph_t  st;
    logic [6:0]  dev_addr;
    logic [7:0]  ptr;
    logic [7:0]  lo;
    logic        hi_half;
    logic        tx_mode;
    logic [7:0]  tx_byte;
    logic        ack_en;
    logic [7:0]  dflt_vin;
    logic [6:0]  dflt_iin;
    chglim_cfg_t cfg;
    logic [10:0] target;
    logic        drv_lvl;
  } chglim_top_t;

  chglim_top_t top_ff;
  chglim_top_t nxt_top;
  chglim_evt_t evt;

  ////////////////////////////////////////////////////////////////////////////
  // byte engine

  chglim_byte_engine u_engine (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .ack_en   (top_ff.ack_en),
    .tx_mode  (top_ff.tx_mode),
    .tx_byte  (top_ff.tx_byte),
    .evt      (evt),
    .sda_oe_n (sda_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register read image

  function automatic logic [15:0] rd_word(input logic [7:0] ofs, input chglim_cfg_t c);
    logic [15:0] w;
    w = 16'h0000;
    case (ofs)
      CHGLIM_OFS_VIN_FLOOR: w = {8'h00, c.vin_min};
      CHGLIM_OFS_IIN_CAP:   w = {9'h000, c.iin_lim};
      CHGLIM_OFS_SRC_VOUT:  w = {c.vsrc_spare, c.source_voltage_offset_sel,
                                 c.vsrc_from_fb, c.vsrc};
      CHGLIM_OFS_COMP_ISRC: w = {2'h0, c.cell_resistance_code, c.comp_clamp_code,
                                 1'b0, c.isrc_lim};
      default:              w = 16'h0000;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register write

  function automatic chglim_cfg_t wr_word(input logic [7:0] ofs, input logic [15:0] d,
                                          input chglim_cfg_t c);
    chglim_cfg_t n;
    n = c;
    case (ofs)
      CHGLIM_OFS_VIN_FLOOR: n.vin_min = d[7:0];
      CHGLIM_OFS_IIN_CAP:   n.iin_lim = d[6:0];
      CHGLIM_OFS_SRC_VOUT: begin
        n.vsrc                      = d[9:0];
        n.vsrc_from_fb              = d[CHGLIM_POS_VSRC_FB];
        n.source_voltage_offset_sel = d[CHGLIM_POS_VSRC_OS];
        n.vsrc_spare                = d[CHGLIM_POS_VSRC_HI +: 4];
      end
      CHGLIM_OFS_COMP_ISRC: begin
        n.cell_resistance_code = d[CHGLIM_POS_CELL_R +: 3];
        n.comp_clamp_code      = d[CHGLIM_POS_CLAMP +: 3];
        n.isrc_lim             = d[6:0];
      end
      default: n = c;
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // transaction sequencing and watchdog

  logic [15:0] rd_cur;
  assign rd_cur = rd_word(top_ff.ptr, top_ff.cfg);

  always_comb begin
    nxt_top = top_ff;
    if (evt.start) begin
      nxt_top.st      = CHGLIM_ADDR;
      nxt_top.tx_mode = 1'b0;
      nxt_top.ack_en  = 1'b0;
    end else if (evt.stop) begin
      nxt_top.st      = CHGLIM_IDLE;
      nxt_top.tx_mode = 1'b0;
      nxt_top.ack_en  = 1'b0;
    end else if (evt.rx_valid) begin
      nxt_top.ack_en = 1'b1;
      case (top_ff.st)
        CHGLIM_ADDR: begin
          if (evt.rx_byte[7:1] == top_ff.dev_addr) begin
            if (evt.rx_byte[0]) begin
              // reads return the low byte first, then the high byte
              nxt_top.st      = CHGLIM_READ;
              nxt_top.tx_mode = 1'b1;
              nxt_top.hi_half = 1'b0;
              nxt_top.tx_byte = rd_cur[7:0];
            end else begin
              nxt_top.st = CHGLIM_CMD;
            end
          end else begin
            nxt_top.st     = CHGLIM_SKIP;
            nxt_top.ack_en = 1'b0;
          end
        end
        CHGLIM_CMD: begin
          nxt_top.ptr = evt.rx_byte;
          nxt_top.st  = CHGLIM_DLO;
        end
        CHGLIM_DLO: begin
          nxt_top.lo = evt.rx_byte;
          nxt_top.st = CHGLIM_DHI;
        end
        CHGLIM_DHI: begin
          // the word lands only when both bytes arrived; extra bytes are dropped
          nxt_top.cfg = wr_word(top_ff.ptr, {evt.rx_byte, top_ff.lo}, top_ff.cfg);
          nxt_top.st  = CHGLIM_SKIP;
        end
        // keep the choice made at the address: a foreign frame stays silent to its stop
        CHGLIM_SKIP: nxt_top.ack_en = top_ff.ack_en;
        default:     nxt_top.ack_en = 1'b0;
      endcase
    end else if (evt.ack_seen && top_ff.st == CHGLIM_READ) begin
      if (evt.host_ack) begin
        nxt_top.hi_half = !top_ff.hi_half;
        nxt_top.tx_byte = top_ff.hi_half ? rd_cur[7:0] : rd_cur[15:8];
      end else begin
        nxt_top.tx_mode = 1'b0;
        nxt_top.st      = CHGLIM_SKIP;
      end
    end
    // watchdog restore wins over a host write landing in the same cycle
    if (supervision_timer_expired) begin
      nxt_top.cfg.vin_min              = top_ff.dflt_vin;
      nxt_top.cfg.iin_lim              = top_ff.dflt_iin;
      nxt_top.cfg.cell_resistance_code = CHGLIM_RST_CELL_R;
      nxt_top.cfg.comp_clamp_code      = CHGLIM_RST_CLAMP;
      nxt_top.cfg.isrc_lim             = CHGLIM_RST_ISRC;
    end
    nxt_top.target = {1'b0, nxt_top.cfg.vsrc}
                   + (nxt_top.cfg.source_voltage_offset_sel ? CHGLIM_VSRC_OFS_STEPS
                                                            : 11'h000);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; OTP and address straps are caught while reset is held

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      top_ff          <= '0;
      top_ff.st       <= CHGLIM_IDLE;
      top_ff.dev_addr <= {otp_addr_hi, DEV_ADDR_LO};
      top_ff.dflt_vin <= otp_valid ? otp_vin_min : CHGLIM_RST_VIN_MIN;
      top_ff.dflt_iin <= otp_valid ? otp_iin_lim : CHGLIM_RST_IIN_LIM;
      top_ff.cfg.vin_min <= otp_valid ? otp_vin_min : CHGLIM_RST_VIN_MIN;
      top_ff.cfg.iin_lim <= otp_valid ? otp_iin_lim : CHGLIM_RST_IIN_LIM;
      top_ff.cfg.vsrc    <= CHGLIM_RST_VSRC;
      top_ff.cfg.isrc_lim <= CHGLIM_RST_ISRC;
      top_ff.cfg.cell_resistance_code <= CHGLIM_RST_CELL_R;
      top_ff.cfg.comp_clamp_code      <= CHGLIM_RST_CLAMP;
      top_ff.target  <= {1'b0, CHGLIM_RST_VSRC};
    end else begin
      top_ff <= nxt_top;
    end
  end

  assign cfg              = top_ff.cfg;
  assign vsrc_target_code = top_ff.target;
  assign sda_out          = top_ff.drv_lvl;

endmodule

// File: test/chglim_setting_bank_props.sv
// checker: port properties of the charger limit setting bank
`timescale 1ns/1ps
module chglim_setting_bank_props (
  input wire logic                    ref_clk,
  input wire logic                    srst,
  input wire logic                    scl_in,
  input wire logic                    sda_oe_n,
  input wire logic                    otp_valid,
  input wire logic [7:0]              otp_vin_min,
  input wire logic [6:0]              otp_iin_lim,
  input wire logic                    supervision_timer_expired,
  input wire chglim_pkg::chglim_cfg_t cfg,
  input wire logic [10:0]             vsrc_target_code
);
  import chglim_pkg::*;
  logic [7:0] vcap_ff;
  logic [6:0] icap_ff;
  // restore values follow the otp choice latched under reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      vcap_ff <= otp_valid ? otp_vin_min : CHGLIM_RST_VIN_MIN;
      icap_ff <= otp_valid ? otp_iin_lim : CHGLIM_RST_IIN_LIM;
    end
  end
  ////////////////////////////////////////
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_rel; $fell(srst); endsequence
  sequence s_wdt; supervision_timer_expired; endsequence
  property p_rst_lim; s_rel |-> cfg.vin_min == vcap_ff && cfg.iin_lim == icap_ff; endproperty
  a_rst_lim: assert property (p_rst_lim) else $error("limits wrong after reset");
  property p_rst_src;
    s_rel |-> cfg.vsrc == CHGLIM_RST_VSRC
      && {cfg.vsrc_spare, cfg.source_voltage_offset_sel, cfg.vsrc_from_fb} == 6'h00;
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("source fields wrong");
  property p_rst_cmp;
    s_rel |-> {cfg.cell_resistance_code, cfg.comp_clamp_code, cfg.isrc_lim}
      == {CHGLIM_RST_CELL_R, CHGLIM_RST_CLAMP, CHGLIM_RST_ISRC};
  endproperty
  a_rst_cmp: assert property (p_rst_cmp) else $error("comp fields wrong");
  property p_wdt_lim; s_wdt |=> cfg.vin_min == vcap_ff && cfg.iin_lim == icap_ff; endproperty
  a_wdt_lim: assert property (p_wdt_lim) else $error("limits not restored");
  property p_wdt_cmp;
    s_wdt |=> {cfg.cell_resistance_code, cfg.comp_clamp_code, cfg.isrc_lim}
      == {6'h00, CHGLIM_RST_ISRC};
  endproperty
  a_wdt_cmp: assert property (p_wdt_cmp) else $error("comp not restored");
  property p_target;
    vsrc_target_code == {1'b0, cfg.vsrc}
      + (cfg.source_voltage_offset_sel ? CHGLIM_VSRC_OFS_STEPS : 11'h000);
  endproperty
  a_target: assert property (p_target) else $error("target code wrong");
  property p_drv; $fell(sda_oe_n) |-> !scl_in; endproperty
  a_drv: assert property (p_drv) else $error("drive began with clock high");
  property p_rel; $rose(sda_oe_n) |-> !scl_in; endproperty
  a_rel: assert property (p_rel) else $error("release with clock high");
endmodule
bind chglim_setting_bank chglim_setting_bank_props chglim_setting_bank_props_i (
  .ref_clk(ref_clk), .srst(srst), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
  .otp_valid(otp_valid), .otp_vin_min(otp_vin_min), .otp_iin_lim(otp_iin_lim),
  .supervision_timer_expired(supervision_timer_expired), .cfg(cfg),
  .vsrc_target_code(vsrc_target_code));

// File: test/chglim_i2c_host.sv
// partner: serial link host framing register writes and reads
`timescale 1ns/1ps
module chglim_i2c_host (
  input  wire logic   ref_clk,
  input  wire logic   sda,
  output logic        scl,
  output logic        sda_drv,
  output logic        rd_valid,
  output logic [15:0] rd_word,
  output logic        nak_seen
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    rd_valid = 1'b0;
    rd_word = 16'h0000;
    nak_seen = 1'b0;
  end
  ////////////////////////////////////////
  task automatic hold(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    hold(4);
    scl = 1'b1;
    hold(2);
    r = sda;
    hold(2);
    scl = 1'b0;
    hold(1);
  endtask
  task automatic start_c();
    sda_drv = 1'b1;
    hold(2);
    scl = 1'b1;
    hold(4);
    sda_drv = 1'b0;
    hold(4);
    scl = 1'b0;
    hold(1);
  endtask
  task automatic stop_c();
    sda_drv = 1'b0;
    hold(2);
    scl = 1'b1;
    hold(4);
    sda_drv = 1'b1;
    hold(6);
  endtask
  task automatic wbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    if (r) nak_seen = 1'b1;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] o, input logic [15:0] d);
    nak_seen = 1'b0;
    start_c();
    wbyte(a);
    wbyte(o);
    wbyte(d[7:0]);
    wbyte(d[15:8]);
    stop_c();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] o);
    logic [7:0] lo;
    logic [7:0] hi;
    start_c();
    wbyte(a);
    wbyte(o);
    start_c();
    wbyte(a | 8'h01);
    rbyte(1'b0, lo);
    rbyte(1'b1, hi);
    stop_c();
    rd_word = {hi, lo};
    rd_valid = 1'b1;
    hold(1);
    rd_valid = 1'b0;
  endtask
endmodule

// File: test/chglim_setting_bank_tb_top.sv
// testbench: register traffic, watchdog restore and defaults of the limit bank
`timescale 1ns/1ps
module chglim_setting_bank_tb_top;
  import chglim_pkg::*;
  localparam logic [7:0] OFS [5] = '{CHGLIM_OFS_VIN_FLOOR, CHGLIM_OFS_IIN_CAP,
    CHGLIM_OFS_SRC_VOUT, CHGLIM_OFS_COMP_ISRC, 8'h07};
  localparam logic [15:0] MSK [5] = '{CHGLIM_MSK_VIN_FLOOR, CHGLIM_MSK_IIN_CAP,
    CHGLIM_MSK_SRC_VOUT, CHGLIM_MSK_COMP_ISRC, 16'h0000};
  localparam logic [15:0] DFLT [5] = '{{8'h00, CHGLIM_RST_VIN_MIN}, {9'h000, CHGLIM_RST_IIN_LIM},
    {6'h00, CHGLIM_RST_VSRC}, {2'h0, CHGLIM_RST_CELL_R, CHGLIM_RST_CLAMP, 1'b0, CHGLIM_RST_ISRC},
    16'h0000};
  logic ref_clk, srst, scl, sda_drv, sda, sda_out, sda_oe_n, otp_valid, wdt, rd_valid, nak;
  logic [7:0] otp_vin;
  logic [6:0] otp_iin;
  logic [3:0] otp_addr;
  logic [15:0] rd_word, d;
  logic [10:0] tgt;
  logic [31:0] rs = 32'h085a;
  chglim_cfg_t cfg;
  logic [15:0] exp_q [$];
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  // pulled-up wire, either side may pull low
  assign sda = sda_drv & (sda_oe_n | sda_out);
  chglim_setting_bank chglim_setting_bank_i (.ref_clk(ref_clk), .srst(srst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .otp_valid(otp_valid),
    .otp_vin_min(otp_vin), .otp_iin_lim(otp_iin), .otp_addr_hi(otp_addr),
    .supervision_timer_expired(wdt), .cfg(cfg), .vsrc_target_code(tgt));
  chglim_i2c_host chglim_i2c_host_i (.ref_clk(ref_clk), .sda(sda), .scl(scl),
    .sda_drv(sda_drv), .rd_valid(rd_valid), .rd_word(rd_word), .nak_seen(nak));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset(input logic ov);
    otp_valid = ov;
    srst = 1'b1;
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic read_all(input logic [15:0] vsrc_exp);
    for (int i = 0; i < 5; i++) begin
      exp_q.push_back(i == 2 ? vsrc_exp : DFLT[i]);
      chglim_i2c_host_i.rd(8'hd2, OFS[i]);
    end
  endtask
  // every read result is paired with the oldest note
  always @(posedge rd_valid) chk(rd_word, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    srst = 1'b1;
    wdt = 1'b0;
    otp_valid = 1'b0;
    otp_vin = 8'h00;
    otp_iin = 7'h00;
    otp_addr = 4'hd;
    do_reset(1'b0);
    read_all(DFLT[2]);
    for (int i = 0; i < 10; i++) begin
      rs = xs(rs);
      d = (i < 5) ? rs[15:0] : 16'hffff;
      chglim_i2c_host_i.wr(8'hd2, OFS[i % 5], d);
      chk({15'h0000, nak}, 16'h0000);
      exp_q.push_back(d & MSK[i % 5]);
      chglim_i2c_host_i.rd(8'hd2, OFS[i % 5]);
    end
    @(negedge ref_clk);
    wdt = 1'b1;
    @(negedge ref_clk);
    wdt = 1'b0;
    read_all(16'hffff);
    for (int k = 0; k < 2; k++) begin
      rs = xs(rs);
      d = {4'h0, k[0], rs[16], rs[9:0]};
      chglim_i2c_host_i.wr(8'hd2, CHGLIM_OFS_SRC_VOUT, d);
      chk({5'h00, tgt}, {6'h00, d[9:0]} + (k[0] ? 16'h0020 : 16'h0000));
      chk({15'h0000, cfg.vsrc_from_fb}, {15'h0000, d[10]});
    end
    chglim_i2c_host_i.wr(8'hd4, OFS[0], 16'h0000);
    chk({15'h0000, nak}, 16'h0001);
    exp_q.push_back(DFLT[0]);
    chglim_i2c_host_i.rd(8'hd2, OFS[0]);
    rs = xs(rs);
    otp_vin = rs[7:0];
    otp_iin = rs[14:8];
    // new upper address bits: the old address must go unanswered
    otp_addr = 4'h5;
    do_reset(1'b1);
    chglim_i2c_host_i.wr(8'hd2, OFS[0], 16'h0000);
    chk({15'h0000, nak}, 16'h0001);
    chglim_i2c_host_i.wr(8'h52, OFS[4], 16'h0000);
    chk({15'h0000, nak}, 16'h0000);
    exp_q.push_back({8'h00, otp_vin});
    chglim_i2c_host_i.rd(8'h52, OFS[0]);
    exp_q.push_back({9'h000, otp_iin});
    chglim_i2c_host_i.rd(8'h52, OFS[1]);
    final_report();
  end
endmodule
